// ==== hdl/rtc_core_pkg.sv ====
// Purpose: Shared constants for the timekeeping core.
// Assumes: 40 MHz system clock, 32.768 kHz crystal level sampled on it.
// Notes: Register indices equal the byte offsets of the register port.
package rtc_core_pkg;
   // ****************************************
   // Register offsets.
   // ****************************************
   localparam logic [3:0] ADDR_SECONDS = 4'h0;
   localparam logic [3:0] ADDR_MINUTES = 4'h1;
   localparam logic [3:0] ADDR_HOURS = 4'h2;
   localparam logic [3:0] ADDR_WEEKDAY = 4'h3;
   localparam logic [3:0] ADDR_MONTH_DAY = 4'h4;
   localparam logic [3:0] ADDR_OSC_ADJUST = 4'h7;
   localparam logic [3:0] ADDR_CONTROL = 4'he;
   localparam logic [3:0] ADDR_STATUS = 4'hf;

   // ****************************************
   // Writable bit masks of the counters.
   // ****************************************
   localparam logic [7:0] MASK_SECONDS = 8'h7f;
   localparam logic [7:0] MASK_MINUTES = 8'h7f;
   localparam logic [7:0] MASK_HOURS = 8'h3f;

   // ****************************************
   // Field positions.
   // ****************************************
   localparam int CTL_WEEKLY_ENABLE = 7;
   localparam int CTL_DAILY_ENABLE = 6;
   localparam int CTL_HOUR_24 = 5;
   localparam int CTL_SLOWCLK_DISABLE_B = 4;
   localparam int STS_VDSL = 7;
   localparam int STS_VDET = 6;
   localparam int STS_OSC_RUNNING = 5;
   localparam int STS_POWER_UP = 4;
   localparam int STS_SLOWCLK_DISABLE_A = 3;
   localparam int STS_PERIODIC = 2;
   localparam int STS_WEEKLY_HIT = 1;
   localparam int STS_DAILY_HIT = 0;
   localparam int HOUR_PM_BIT = 5;

   // ****************************************
   // Reset values after power-up.
   // ****************************************
   localparam logic [7:0] RST_SECONDS = 8'h00;
   localparam logic [7:0] RST_MINUTES = 8'h00;
   localparam logic [7:0] RST_HOURS = 8'h12;
   localparam logic [2:0] RST_WEEKDAY = 3'h0;
   localparam logic [5:0] RST_MONTH_DAY = 6'h01;

   // ****************************************
   // Timing.
   // ****************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int XTAL_PER_SECOND = 32768;
   localparam int ALARM_DELAY_NS = 61000;
   localparam int ALARM_DELAY_CYCLES = ALARM_DELAY_NS / CLK_PERIOD_NS;
endpackage

// ==== hdl/rtc_core.sv ====
// Purpose: BCD time counters, status flags, interrupt and slow clock pins.
// Assumes: Synchronous strobe register port and crystal level.
// Notes: Pins are open drain and are given as output enables only.
//
// Behaviour
// RULE_01: Oscillator halt clears running flag; stays cleared.
// RULE_02: Software reads and writes the running flag.
// RULE_03: Power-up sets the power-up flag to one.
// RULE_04: Power-up flag holds control bits at zero.
// RULE_05: Power-up flag clears only on written zero.
// RULE_06: Slow clock runs unless both disables set.
// RULE_07: Periodic flag reads one while pin low.
// RULE_08: Writing zero in level mode releases pin.
// RULE_09: Enabled alarm flag sets 61 us after match.
// RULE_10: Writing zero clears alarm flag, releases pin.
// RULE_11: Disabled alarm reads its flag as zero.
// RULE_12: Alarm flag follows the interrupt pin exactly; here the periodic flag also pulls the pin low.
// RULE_13: Seconds count 00 to 59, carry minutes.
// RULE_14: Minutes count 00 to 59, carry hours.
// RULE_15: Hour rollover carries to both day counters.
// RULE_16: Writing seconds restarts the sub-second divider.
// RULE_17: Host writes only valid time values.
// RULE_18: Weekday counts 0 to 6 then wraps.
// RULE_19: Host avoids weekday code seven.
// RULE_20: Format bit picks 12 or 24 hour.
// RULE_21: Month day limited by month and leap.
// RULE_22: Seconds advance every 32768 crystal cycles.
// RULE_23: Unused counter bits read zero, ignore writes.
`timescale 1ns/100ps
module rtc_core #(
   parameter int DIV_COUNT = rtc_core_pkg::XTAL_PER_SECOND
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_xtal_clk,
   input wire logic i_osc_halt,
   input wire logic [3:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_weekly_alarm_match,
   input wire logic i_daily_alarm_match,
   input wire logic [7:0] i_month_bcd,
   input wire logic i_leap_year,
   output logic [7:0] o_reg_rdata,
   output logic o_irq_out_n_oe_n,
   output logic o_slow_clock_out_oe_n,
   output logic o_month_carry
);
   // ****************************************
   // State.
   // ****************************************
   typedef struct packed {
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [2:0] wday;
      logic [5:0] mday;
      logic [6:0] adjust;
      logic [7:0] ctrl;
      logic vdsl;
      logic vdet;
      logic osc_running_flag;
      logic power_up_flag;
      logic slowclk_disable_a;
      logic periodic_irq_flag;
      logic weekly_alarm_hit;
      logic daily_alarm_hit;
      logic [14:0] div;
      logic xtal_prev;
      logic [11:0] wdelay;
      logic [11:0] ddelay;
      logic wpend;
      logic dpend;
      logic irq_oe_n;
      logic clk_oe_n;
      logic [7:0] rdata;
      logic month_carry;
   } state_t;

   state_t st;
   state_t next_st;
   logic xtal_rise;
   logic sec_tick;
   logic wr_status;

   // ****************************************
   // Arithmetic helpers.
   // ****************************************
   // Adds one to a two-digit BCD value.
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
   endfunction

   // Steps the hour in either format; bit 8 of the result is the day carry.
   function automatic logic [8:0] hour_step(input logic [7:0] h, input logic fmt24);
      logic [8:0] r;
      r = {1'b0, bcd_inc(h)};
      if (fmt24) begin
         if (h == 8'h23) begin
            r = {1'b1, 8'h00};
         end
      end else if (h[4:0] == 5'h12) begin
         r = {1'b0, 2'b00, h[rtc_core_pkg::HOUR_PM_BIT], 5'h01};
      end else if (h[4:0] == 5'h11) begin
         r = {h[rtc_core_pkg::HOUR_PM_BIT], 2'b00, ~h[rtc_core_pkg::HOUR_PM_BIT], 5'h12};
      end
      return r;
   endfunction

   // Gives the last day of the month in BCD.
   function automatic logic [5:0] last_day(input logic [7:0] mon, input logic leap);
      return (mon == 8'h02) ? (leap ? 6'h29 : 6'h28)
         : (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) ? 6'h30 : 6'h31;
   endfunction

   // Crystal edge and the one-second boundary of the divider.
   assign xtal_rise = i_xtal_clk & ~st.xtal_prev;
   assign sec_tick = xtal_rise && (st.div == 15'(DIV_COUNT - 1)); // RULE_22
   assign wr_status = i_reg_wr && (i_reg_addr == rtc_core_pkg::ADDR_STATUS);

   // ****************************************
   // Next-state logic.
   // ****************************************
   // Counters, flags, register writes and reads in one pass.
   always_comb begin
      logic min_tick;
      logic hour_tick;
      logic day_tick;
      logic month_tick;
      logic level_event;
      logic [8:0] hstep;
      min_tick = 1'b0;
      hour_tick = 1'b0;
      day_tick = 1'b0;
      month_tick = 1'b0;
      level_event = 1'b0;
      hstep = hour_step(st.hour, st.ctrl[rtc_core_pkg::CTL_HOUR_24]); // RULE_20
      next_st = st;
      next_st.xtal_prev = i_xtal_clk;
      next_st.month_carry = 1'b0;
      // Sub-second divider.
      if (xtal_rise) begin
         next_st.div = (st.div == 15'(DIV_COUNT - 1)) ? 15'h0000 : st.div + 15'h0001; // RULE_22
      end
      // Carry chain.
      if (sec_tick) begin
         if (st.sec == 8'h59) begin
            next_st.sec = 8'h00; // RULE_13
            min_tick = 1'b1;
         end else begin
            next_st.sec = bcd_inc(st.sec); // RULE_13
         end
      end
      if (min_tick) begin
         if (st.min == 8'h59) begin
            next_st.min = 8'h00; // RULE_14
            hour_tick = 1'b1;
         end else begin
            next_st.min = bcd_inc(st.min); // RULE_14
         end
      end
      if (hour_tick) begin
         next_st.hour = hstep[7:0];
         day_tick = hstep[8]; // RULE_15
      end
      if (day_tick) begin
         next_st.wday = (st.wday == 3'h6) ? 3'h0 : st.wday + 3'h1; // RULE_18
         if (st.mday == last_day(i_month_bcd, i_leap_year)) begin
            next_st.mday = 6'h01; // RULE_21
            month_tick = 1'b1;
         end else begin
            next_st.mday = 6'(bcd_inc({2'b00, st.mday})); // RULE_21
         end
      end
      next_st.month_carry = month_tick;
      // Counter, adjust and control writes; unused upper bits are dropped.
      if (i_reg_wr) begin
         if (i_reg_addr == rtc_core_pkg::ADDR_SECONDS) begin
            next_st.sec = i_reg_wdata & rtc_core_pkg::MASK_SECONDS; // RULE_23
            next_st.div = 15'h0000; // RULE_16
         end else if (i_reg_addr == rtc_core_pkg::ADDR_MINUTES) begin
            next_st.min = i_reg_wdata & rtc_core_pkg::MASK_MINUTES; // RULE_23
         end else if (i_reg_addr == rtc_core_pkg::ADDR_HOURS) begin
            next_st.hour = i_reg_wdata & rtc_core_pkg::MASK_HOURS; // RULE_23
         end else if (i_reg_addr == rtc_core_pkg::ADDR_WEEKDAY) begin
            next_st.wday = i_reg_wdata[2:0]; // RULE_23
         end else if (i_reg_addr == rtc_core_pkg::ADDR_MONTH_DAY) begin
            next_st.mday = i_reg_wdata[5:0]; // RULE_23
         end else if (i_reg_addr == rtc_core_pkg::ADDR_OSC_ADJUST) begin
            next_st.adjust = i_reg_wdata[6:0];
         end else if (i_reg_addr == rtc_core_pkg::ADDR_CONTROL) begin
            next_st.ctrl = i_reg_wdata;
         end
      end
      // Status writes: plain bits store, flag bits clear only on zero.
      if (wr_status) begin
         next_st.vdsl = i_reg_wdata[rtc_core_pkg::STS_VDSL];
         next_st.vdet = st.vdet & i_reg_wdata[rtc_core_pkg::STS_VDET];
         next_st.osc_running_flag = i_reg_wdata[rtc_core_pkg::STS_OSC_RUNNING]; // RULE_02
         next_st.power_up_flag = st.power_up_flag & i_reg_wdata[rtc_core_pkg::STS_POWER_UP]; // RULE_05
         next_st.slowclk_disable_a = i_reg_wdata[rtc_core_pkg::STS_SLOWCLK_DISABLE_A];
         next_st.weekly_alarm_hit = st.weekly_alarm_hit & i_reg_wdata[rtc_core_pkg::STS_WEEKLY_HIT]; // RULE_10
         next_st.daily_alarm_hit = st.daily_alarm_hit & i_reg_wdata[rtc_core_pkg::STS_DAILY_HIT]; // RULE_10
      end
      // A sensed halt wins over a software write of one.
      if (i_osc_halt) begin
         next_st.osc_running_flag = 1'b0; // RULE_01
      end
      // Periodic interrupt: fixed, pulse or level mode.
      case (st.ctrl[2:0])
         3'b000: next_st.periodic_irq_flag = 1'b0;
         3'b001: next_st.periodic_irq_flag = 1'b1;
         3'b010: next_st.periodic_irq_flag = ~next_st.div[13]; // RULE_07
         3'b011: next_st.periodic_irq_flag = ~next_st.div[14]; // RULE_07
         3'b100: level_event = sec_tick;
         3'b101: level_event = min_tick;
         3'b110: level_event = hour_tick;
         default: level_event = month_tick;
      endcase
      if (st.ctrl[2] && wr_status && !i_reg_wdata[rtc_core_pkg::STS_PERIODIC]) begin
         next_st.periodic_irq_flag = 1'b0; // RULE_08
      end
      if (level_event) begin
         next_st.periodic_irq_flag = 1'b1; // RULE_07
      end
      // Alarm matches are delayed before the flag rises.
      if (st.wpend) begin
         next_st.wdelay = st.wdelay - 12'h001;
         if (st.wdelay == 12'h000) begin
            next_st.wpend = 1'b0;
            next_st.weekly_alarm_hit = 1'b1; // RULE_09
         end
      end
      if (i_weekly_alarm_match && st.ctrl[rtc_core_pkg::CTL_WEEKLY_ENABLE]) begin
         next_st.wpend = 1'b1;
         next_st.wdelay = 12'(rtc_core_pkg::ALARM_DELAY_CYCLES - 2); // RULE_09
      end
      if (st.dpend) begin
         next_st.ddelay = st.ddelay - 12'h001;
         if (st.ddelay == 12'h000) begin
            next_st.dpend = 1'b0;
            next_st.daily_alarm_hit = 1'b1; // RULE_09
         end
      end
      if (i_daily_alarm_match && st.ctrl[rtc_core_pkg::CTL_DAILY_ENABLE]) begin
         next_st.dpend = 1'b1;
         next_st.ddelay = 12'(rtc_core_pkg::ALARM_DELAY_CYCLES - 2); // RULE_09
      end
      // A disabled alarm holds its flag and delay at rest.
      if (!next_st.ctrl[rtc_core_pkg::CTL_WEEKLY_ENABLE]) begin
         next_st.weekly_alarm_hit = 1'b0; // RULE_11
         next_st.wpend = 1'b0;
      end
      if (!next_st.ctrl[rtc_core_pkg::CTL_DAILY_ENABLE]) begin
         next_st.daily_alarm_hit = 1'b0; // RULE_11
         next_st.dpend = 1'b0;
      end
      // The power-up flag holds control state at zero.
      if (next_st.power_up_flag) begin
         next_st.ctrl = 8'h00; // RULE_04
         next_st.adjust = 7'h00; // RULE_04
         next_st.vdsl = 1'b0;
         next_st.vdet = 1'b0;
         next_st.slowclk_disable_a = 1'b0;
         next_st.periodic_irq_flag = 1'b0;
         next_st.weekly_alarm_hit = 1'b0;
         next_st.daily_alarm_hit = 1'b0;
         next_st.wpend = 1'b0;
         next_st.dpend = 1'b0;
      end
      // Pins follow the flags in the same cycle.
      next_st.irq_oe_n = ~(next_st.periodic_irq_flag | next_st.weekly_alarm_hit | next_st.daily_alarm_hit); // RULE_12
      next_st.clk_oe_n = (next_st.slowclk_disable_a & next_st.ctrl[rtc_core_pkg::CTL_SLOWCLK_DISABLE_B])
         | i_xtal_clk; // RULE_06
      // Read data is sampled on the read strobe.
      if (i_reg_rd) begin
         if (i_reg_addr == rtc_core_pkg::ADDR_SECONDS) begin
            next_st.rdata = st.sec;
         end else if (i_reg_addr == rtc_core_pkg::ADDR_MINUTES) begin
            next_st.rdata = st.min;
         end else if (i_reg_addr == rtc_core_pkg::ADDR_HOURS) begin
            next_st.rdata = st.hour;
         end else if (i_reg_addr == rtc_core_pkg::ADDR_WEEKDAY) begin
            next_st.rdata = {5'h00, st.wday}; // RULE_23
         end else if (i_reg_addr == rtc_core_pkg::ADDR_MONTH_DAY) begin
            next_st.rdata = {2'b00, st.mday}; // RULE_23
         end else if (i_reg_addr == rtc_core_pkg::ADDR_OSC_ADJUST) begin
            next_st.rdata = {1'b0, st.adjust};
         end else if (i_reg_addr == rtc_core_pkg::ADDR_CONTROL) begin
            next_st.rdata = st.ctrl;
         end else if (i_reg_addr == rtc_core_pkg::ADDR_STATUS) begin
            next_st.rdata = {st.vdsl, st.vdet, st.osc_running_flag, st.power_up_flag,
               st.slowclk_disable_a, st.periodic_irq_flag, st.weekly_alarm_hit, st.daily_alarm_hit};
         end else begin
            next_st.rdata = 8'h00;
         end
      end
   end

   // ****************************************
   // State register.
   // ****************************************
   // Reset stands for power-up from zero volts.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         st <= '0;
         st.sec <= rtc_core_pkg::RST_SECONDS;
         st.min <= rtc_core_pkg::RST_MINUTES;
         st.hour <= rtc_core_pkg::RST_HOURS;
         st.wday <= rtc_core_pkg::RST_WEEKDAY;
         st.mday <= rtc_core_pkg::RST_MONTH_DAY;
         st.power_up_flag <= 1'b1; // RULE_03
         st.irq_oe_n <= 1'b1;
         st.clk_oe_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign o_reg_rdata = st.rdata;
   assign o_irq_out_n_oe_n = st.irq_oe_n;
   assign o_slow_clock_out_oe_n = st.clk_oe_n;
   assign o_month_carry = st.month_carry;

   // ****************************************
   // Assertions.
   // ****************************************
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);

   a_halt_clears_flag: assert property (i_osc_halt |=> !st.osc_running_flag) // RULE_01
      else $error("running flag not cleared by halt");
   a_running_flag_write: assert property (wr_status && !i_osc_halt
      |=> st.osc_running_flag == $past(i_reg_wdata[5])) // RULE_02
      else $error("running flag write lost");
   a_power_up_set: assert property ($rose(i_rst_n) |-> st.power_up_flag) // RULE_03
      else $error("power-up flag not set after reset");
   a_power_up_hold: assert property (st.power_up_flag |-> st.ctrl == 8'h00 && st.adjust == 7'h00
      && o_irq_out_n_oe_n) // RULE_04
      else $error("control not held while power-up flag set");
   a_power_up_one: assert property (wr_status && i_reg_wdata[4] && !st.power_up_flag
      |=> !st.power_up_flag) // RULE_05
      else $error("writing one set power-up flag");
   a_slowclk_disable: assert property (st.slowclk_disable_a && st.ctrl[4] |-> o_slow_clock_out_oe_n) // RULE_06
      else $error("slow clock driven while disabled");
   a_irq_follow: assert property (!o_irq_out_n_oe_n == (st.periodic_irq_flag || st.weekly_alarm_hit
      || st.daily_alarm_hit)) // RULE_12
      else $error("interrupt pin out of step with flags");
   a_alarm_delay: assert property ($rose(st.weekly_alarm_hit) |-> $past(st.wpend)
      && $past(st.wdelay) == 12'h000) // RULE_09
      else $error("weekly alarm flag rose without delay");
   a_alarm_disabled: assert property (!st.ctrl[7] |-> !st.weekly_alarm_hit) // RULE_11
      else $error("disabled alarm flag reads one");
   a_second_wrap: assert property (sec_tick && st.sec == 8'h59 && !i_reg_wr
      |=> st.sec == 8'h00 && st.min != $past(st.min)) // RULE_13
      else $error("second wrap without minute carry");
   a_divider_restart: assert property (i_reg_wr && i_reg_addr == 4'h0 |=> st.div == 15'h0000) // RULE_16
      else $error("divider not restarted on second write");
   a_weekday_wrap: assert property (st.wday == 3'h6 && !i_reg_wr && sec_tick && st.sec == 8'h59
      && st.min == 8'h59 && st.hour == 8'h23 && st.ctrl[5] |=> st.wday == 3'h0) // RULE_18
      else $error("weekday did not wrap from six");

   c_second_wrap: cover property (sec_tick && st.sec == 8'h59);
   c_weekly_hit: cover property ($rose(st.weekly_alarm_hit));
   c_periodic_level: cover property ($rose(st.periodic_irq_flag) && st.ctrl[2]);
   c_month_carry: cover property (st.month_carry);
endmodule

// ==== tb/rtc_host_model.sv ====
// Purpose: Host processor model that reads and writes the core's registers.
// Assumes: One strobe per transfer, launched and released just after a rising edge.
// Notes: A released bus shows the inverse of the last value.
`timescale 1ns/100ps
module rtc_host_model (
   input wire logic i_clk_sys,
   input wire logic [7:0] i_reg_rdata,
   output logic [3:0] o_reg_addr,
   output logic o_reg_wr,
   output logic o_reg_rd,
   output logic [7:0] o_reg_wdata
);
   // ****************************************
   // Idle bus.
   // ****************************************
   // The port starts idle so that nothing is taken during reset.
   initial begin
      o_reg_addr = 4'h0;
      o_reg_wr = 1'b0;
      o_reg_rd = 1'b0;
      o_reg_wdata = 8'h00;
   end

   // ****************************************
   // Transfers.
   // ****************************************
   // One write of the given value; the value is passed on unchecked.
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge i_clk_sys);
      o_reg_addr <= a;
      o_reg_wdata <= v;
      o_reg_wr <= 1'b1;
      @(posedge i_clk_sys);
      o_reg_wr <= 1'b0;
      o_reg_addr <= ~a;
      o_reg_wdata <= ~v;
   endtask

   // One read; data is taken just after the taking edge.
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge i_clk_sys);
      o_reg_addr <= a;
      o_reg_rd <= 1'b1;
      @(posedge i_clk_sys);
      o_reg_rd <= 1'b0;
      o_reg_addr <= ~a;
      #1;
      d = i_reg_rdata;
   endtask
endmodule

// ==== tb/rtc_time_counters_status_flags_bench.sv ====
// Purpose: Self-checking bench for the timekeeping core.
// Assumes: One second is 8 crystal edges; the crystal runs at one eighth of the system clock.
// Notes: Each scenario is a task that drives the core and judges the answers.
`timescale 1ns/100ps
module rtc_time_counters_status_flags_bench;
   logic i_clk_sys = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_xtal_clk = 1'b0;
   logic i_osc_halt = 1'b0;
   logic i_weekly_alarm_match = 1'b0;
   logic i_daily_alarm_match = 1'b0;
   logic [7:0] i_month_bcd = 8'h01;
   logic i_leap_year = 1'b0;
   logic [3:0] reg_addr;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_wdata;
   logic [7:0] o_reg_rdata;
   logic o_irq_out_n_oe_n;
   logic o_slow_clock_out_oe_n;
   logic o_month_carry;
   logic [2:0] xtal_div = 3'h0;
   logic carry_seen = 1'b0;
   int miscompares = 0;
   int n_tests = 0;

   // ****************************************
   // Clocks, crystal and instances.
   // ****************************************
   // The system clock runs at 40 MHz.
   always #12.5 i_clk_sys = ~i_clk_sys;

   // Crystal toggles every four cycles; month carries are latched.
   always @(posedge i_clk_sys) begin
      xtal_div <= xtal_div + 3'h1;
      i_xtal_clk <= xtal_div[2];
      if (o_month_carry === 1'b1) carry_seen <= 1'b1;
   end

   rtc_core #(.DIV_COUNT(8)) rtc_core_inst (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_xtal_clk(i_xtal_clk),
      .i_osc_halt(i_osc_halt), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
      .i_reg_wdata(reg_wdata), .i_weekly_alarm_match(i_weekly_alarm_match),
      .i_daily_alarm_match(i_daily_alarm_match), .i_month_bcd(i_month_bcd), .i_leap_year(i_leap_year),
      .o_reg_rdata(o_reg_rdata), .o_irq_out_n_oe_n(o_irq_out_n_oe_n),
      .o_slow_clock_out_oe_n(o_slow_clock_out_oe_n), .o_month_carry(o_month_carry));

   rtc_host_model rtc_host_model_inst (.i_clk_sys(i_clk_sys), .i_reg_rdata(o_reg_rdata), .o_reg_addr(reg_addr),
      .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_wdata(reg_wdata));

   // ****************************************
   // Shared tasks.
   // ****************************************
   // Compares one value and counts the outcome.
   task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Reads a register and compares it.
   task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rtc_host_model_inst.rd(a, d);
      chk(what, d, exp);
   endtask

   // Writes a register.
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      rtc_host_model_inst.wr(a, v);
   endtask

   // Waits up to lim cycles for a pin level, then judges it.
   task automatic wait_irq(input logic lvl, input int lim);
      for (int i = 0; i < lim && o_irq_out_n_oe_n !== lvl; i++) begin
         @(posedge i_clk_sys);
         #1;
      end
      chk("irq pin enable", {7'h0, o_irq_out_n_oe_n}, {7'h0, lvl});
   endtask

   // Counts the cycles in 32 that the slow clock pin is pulled low.
   task automatic count_low(input logic [7:0] exp);
      logic [7:0] n;
      n = 8'h00;
      repeat (4) @(posedge i_clk_sys);
      repeat (32) begin
         @(posedge i_clk_sys);
         #1;
         if (o_slow_clock_out_oe_n === 1'b0) n++;
      end
      chk("slow clock low cycles", n, exp);
   endtask

   // Presets the last second of a month, then lets it pass.
   task automatic roll(input logic [7:0] ctl, input logic [7:0] hr, input logic [7:0] exp_hr);
      wr(rtc_core_pkg::ADDR_CONTROL, ctl);
      wr(rtc_core_pkg::ADDR_HOURS, hr);
      wr(rtc_core_pkg::ADDR_MINUTES, 8'h59);
      wr(rtc_core_pkg::ADDR_WEEKDAY, 8'h06);
      wr(rtc_core_pkg::ADDR_MONTH_DAY, 8'h31);
      carry_seen = 1'b0;
      wr(rtc_core_pkg::ADDR_SECONDS, 8'h59);
      repeat (40) @(posedge i_clk_sys);
      rchk("seconds held", rtc_core_pkg::ADDR_SECONDS, 8'h59);
      repeat (40) @(posedge i_clk_sys);
      rchk("seconds", rtc_core_pkg::ADDR_SECONDS, 8'h00);
      rchk("minutes", rtc_core_pkg::ADDR_MINUTES, 8'h00);
      rchk("hours", rtc_core_pkg::ADDR_HOURS, exp_hr);
      rchk("weekday", rtc_core_pkg::ADDR_WEEKDAY, 8'h00);
      rchk("month day", rtc_core_pkg::ADDR_MONTH_DAY, 8'h01);
      chk("month carry", {7'h0, carry_seen}, 8'h01);
      $display("test rollover %h done", hr);
   endtask

   // ****************************************
   // Scenarios.
   // ****************************************
   // Power-up values, forced control bits and the power-up flag.
   task automatic t_power_up();
      rchk("seconds", rtc_core_pkg::ADDR_SECONDS, 8'h00);
      rchk("hours", rtc_core_pkg::ADDR_HOURS, 8'h12);
      rchk("status", rtc_core_pkg::ADDR_STATUS, 8'h10);
      wait_irq(1'b1, 1);
      count_low(8'd16);
      wr(rtc_core_pkg::ADDR_CONTROL, 8'hff);
      rchk("control forced", rtc_core_pkg::ADDR_CONTROL, 8'h00);
      wr(rtc_core_pkg::ADDR_STATUS, 8'h10);
      rchk("status", rtc_core_pkg::ADDR_STATUS, 8'h10);
      wr(rtc_core_pkg::ADDR_STATUS, 8'h00);
      rchk("status", rtc_core_pkg::ADDR_STATUS, 8'h00);
      wr(rtc_core_pkg::ADDR_STATUS, 8'h10);
      rchk("status", rtc_core_pkg::ADDR_STATUS, 8'h00);
      $display("test power up done");
   endtask

   // Oscillator flag written, then cleared by a halt and kept cleared.
   task automatic t_osc();
      wr(rtc_core_pkg::ADDR_STATUS, 8'h20);
      rchk("status", rtc_core_pkg::ADDR_STATUS, 8'h20);
      @(posedge i_clk_sys) i_osc_halt <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      i_osc_halt <= 1'b0;
      rchk("status", rtc_core_pkg::ADDR_STATUS, 8'h00);
      repeat (20) @(posedge i_clk_sys);
      rchk("status", rtc_core_pkg::ADDR_STATUS, 8'h00);
      $display("test oscillator flag done");
   endtask

   // Slow clock runs unless both disable bits are set.
   task automatic t_slow_clock();
      wr(rtc_core_pkg::ADDR_STATUS, 8'h08);
      count_low(8'd16);
      wr(rtc_core_pkg::ADDR_CONTROL, 8'h10);
      count_low(8'd0);
      wr(rtc_core_pkg::ADDR_STATUS, 8'h00);
      count_low(8'd16);
      wr(rtc_core_pkg::ADDR_CONTROL, 8'h00);
      $display("test slow clock done");
   endtask

   // Unused bits and an unmapped place read as zero.
   task automatic t_unused();
      wr(rtc_core_pkg::ADDR_WEEKDAY, 8'hf5);
      rchk("weekday", rtc_core_pkg::ADDR_WEEKDAY, 8'h05);
      rchk("unmapped", 4'h9, 8'h00);
      $display("test unused bits done");
   endtask

   // Enabled alarm sets its flag and pin late; a disabled one stays silent.
   task automatic t_alarm();
      wr(rtc_core_pkg::ADDR_CONTROL, 8'h80);
      @(posedge i_clk_sys) i_weekly_alarm_match <= 1'b1;
      @(posedge i_clk_sys) i_weekly_alarm_match <= 1'b0;
      repeat (2400) @(posedge i_clk_sys);
      wait_irq(1'b1, 1);
      wait_irq(1'b0, 100);
      rchk("status", rtc_core_pkg::ADDR_STATUS, 8'h02);
      wr(rtc_core_pkg::ADDR_STATUS, 8'h02);
      rchk("status", rtc_core_pkg::ADDR_STATUS, 8'h02);
      wr(rtc_core_pkg::ADDR_STATUS, 8'h00);
      wait_irq(1'b1, 2);
      rchk("status", rtc_core_pkg::ADDR_STATUS, 8'h00);
      @(posedge i_clk_sys) i_daily_alarm_match <= 1'b1;
      @(posedge i_clk_sys) i_daily_alarm_match <= 1'b0;
      repeat (2500) @(posedge i_clk_sys);
      rchk("status", rtc_core_pkg::ADDR_STATUS, 8'h00);
      wait_irq(1'b1, 1);
      $display("test alarms done");
   endtask

   // Once-a-second level interrupt is flagged and released by a written zero.
   task automatic t_periodic();
      wr(rtc_core_pkg::ADDR_CONTROL, 8'h04);
      wait_irq(1'b0, 100);
      rchk("status", rtc_core_pkg::ADDR_STATUS, 8'h04);
      wr(rtc_core_pkg::ADDR_STATUS, 8'h00);
      wait_irq(1'b1, 2);
      rchk("status", rtc_core_pkg::ADDR_STATUS, 8'h00);
      wr(rtc_core_pkg::ADDR_CONTROL, 8'h00);
      $display("test periodic done");
   endtask

   // ****************************************
   // Run control.
   // ****************************************
   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // Reset, then the scenarios.
   initial begin
      repeat (5) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      t_power_up();
      t_osc();
      t_slow_clock();
      t_unused();
      roll(8'h20, 8'h23, 8'h00);
      roll(8'h00, 8'h31, 8'h12);
      t_alarm();
      t_periodic();
      give_verdict();
   end

   // Ends a hung run.
   initial begin
      repeat (20000) @(posedge i_clk_sys);
      miscompares++;
      give_verdict();
   end
endmodule
